// *** logic/bsf_exec.sv ***
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module bsf_exec (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire bsf_pkg::bsf_apb_t apb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core state
  output logic [7:0]             flags,
  output logic                   busy
);

  logic [7:0]        rf_q [32];
  logic [7:0]        io_q [32];
  logic [7:0]        mem_q [256];
  logic [7:0]        flags_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic              busy_q;
  bsf_pkg::bsf_st_t  st_q;
  bsf_pkg::bsf_cmd_t cmd_q;
  logic [7:0]        addr_q;
  logic [15:0]       nptr_q;
  bsf_pkg::bsf_rgn_t rgn;
  logic              acc;
  logic              go;
  logic              wr;
  logic              launch;
  logic [4:0]        op;
  logic [7:0]        rdv;
  logic [7:0]        rrv;
  logic [7:0]        sres;
  logic              sc;
  logic [4:0]        pb;
  logic [15:0]       ptr;
  logic [15:0]       eff;
  logic [15:0]       nptr;

  function automatic bsf_pkg::bsf_rgn_t region(input logic [11:0] a);
    if (a == bsf_pkg::A_CMD) begin
      return bsf_pkg::RG_CMD;
    end else if (a == bsf_pkg::A_FLG) begin
      return bsf_pkg::RG_FLG;
    end else if ((a & ~bsf_pkg::M_RF) == bsf_pkg::A_RF) begin
      return bsf_pkg::RG_RF;
    end else if ((a & ~bsf_pkg::M_IO) == bsf_pkg::A_IO) begin
      return bsf_pkg::RG_IO;
    end else if ((a & ~bsf_pkg::M_MEM) == bsf_pkg::A_MEM) begin
      return bsf_pkg::RG_MEM;
    end else begin
      return bsf_pkg::RG_NONE;
    end
  endfunction

  function automatic logic is_shift(input logic [4:0] o);
    return o == bsf_pkg::OP_SHL || o == bsf_pkg::OP_SHR || o == bsf_pkg::OP_RLC ||
           o == bsf_pkg::OP_RRC || o == bsf_pkg::OP_SAR;
  endfunction

  function automatic logic is_mrd(input logic [4:0] o);
    return o >= bsf_pkg::OP_MRD_X && o <= bsf_pkg::OP_MRD_ZI;
  endfunction

  function automatic logic is_long(input logic [4:0] o);
    return is_mrd(o) || o == bsf_pkg::OP_IOSET || o == bsf_pkg::OP_IOCLR;
  endfunction

  function automatic logic ptr_upd(input logic [4:0] o);
    return o == bsf_pkg::OP_MRD_XI || o == bsf_pkg::OP_MRD_XD || o == bsf_pkg::OP_MRD_YI ||
           o == bsf_pkg::OP_MRD_YD || o == bsf_pkg::OP_MRD_ZI;
  endfunction

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign flags   = flags_q;
  assign busy    = busy_q;

  // one wait state; writes held off while a command runs
  assign rgn    = region(apb.paddr);
  assign acc    = apb.psel & apb.penable;
  assign go     = acc & ~pready_q & ~(busy_q & apb.pwrite);
  assign wr     = acc & pready_q & apb.pwrite;
  assign launch = wr && rgn == bsf_pkg::RG_CMD;
  assign op     = cmd_q.op;
  assign rdv    = rf_q[cmd_q.rd];
  assign rrv    = rf_q[cmd_q.rr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= go;
      pslverr_q <= go && rgn == bsf_pkg::RG_NONE;
      if (go && !apb.pwrite) begin
        if (rgn == bsf_pkg::RG_CMD) begin
          prdata_q <= cmd_q;
        end else if (rgn == bsf_pkg::RG_FLG) begin
          prdata_q <= {23'h0, busy_q, flags_q};
        end else if (rgn == bsf_pkg::RG_RF) begin
          prdata_q <= {24'h0, rf_q[apb.paddr[6:2]]};
        end else if (rgn == bsf_pkg::RG_IO) begin
          prdata_q <= {24'h0, io_q[apb.paddr[6:2]]};
        end else if (rgn == bsf_pkg::RG_MEM) begin
          prdata_q <= {24'h0, mem_q[apb.paddr[9:2]]};
        end else begin
          prdata_q <= 32'h0;
        end
      end
    end
  end

  // sequencer: short commands end after EXEC, long ones after FIN
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= bsf_pkg::ST_IDLE;
      busy_q <= 1'b0;
      cmd_q  <= '0;
    end else begin
      case (st_q)
        bsf_pkg::ST_IDLE: begin
          if (launch) begin
            st_q   <= bsf_pkg::ST_EXEC;
            busy_q <= 1'b1;
            cmd_q  <= apb.pwdata;
          end
        end
        bsf_pkg::ST_EXEC: begin
          if (is_long(op)) begin
            st_q <= bsf_pkg::ST_FIN;
          end else begin
            st_q   <= bsf_pkg::ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          st_q   <= bsf_pkg::ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    sres = rdv;
    sc   = flags_q[bsf_pkg::F_C];
    case (op)
      bsf_pkg::OP_SHL: begin
        sres = {rdv[6:0], 1'b0};
        sc   = rdv[7];
      end
      bsf_pkg::OP_SHR: begin
        sres = {1'b0, rdv[7:1]};
        sc   = rdv[0];
      end
      bsf_pkg::OP_RLC: begin
        sres = {rdv[6:0], flags_q[bsf_pkg::F_C]};
        sc   = rdv[7];
      end
      bsf_pkg::OP_RRC: begin
        sres = {flags_q[bsf_pkg::F_C], rdv[7:1]};
        sc   = rdv[0];
      end
      bsf_pkg::OP_SAR: begin
        sres = {rdv[7], rdv[7:1]};
        sc   = rdv[0];
      end
      default: begin
        sres = rdv;
      end
    endcase
  end

  // pointer pairs are even-aligned, so the high byte is pb | 1
  always_comb begin
    if (op == bsf_pkg::OP_MRD_X || op == bsf_pkg::OP_MRD_XI || op == bsf_pkg::OP_MRD_XD) begin
      pb = bsf_pkg::R_X;
    end else if (op == bsf_pkg::OP_MRD_Z || op == bsf_pkg::OP_MRD_ZI) begin
      pb = bsf_pkg::R_Z;
    end else begin
      pb = bsf_pkg::R_Y;
    end
    ptr  = {rf_q[pb | 5'h01], rf_q[pb]};
    eff  = ptr;
    nptr = ptr + 16'h0001;
    if (op == bsf_pkg::OP_MRD_XD || op == bsf_pkg::OP_MRD_YD) begin
      eff  = ptr - 16'h0001;
      nptr = eff;
    end else if (op == bsf_pkg::OP_MRD_YQ) begin
      eff = ptr + {10'h0, cmd_q.imm[5:0]};
    end
  end

  // only 256 bytes of data space: the pointer's high byte is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= 8'h00;
      nptr_q <= 16'h0;
    end else if (st_q == bsf_pkg::ST_EXEC) begin
      addr_q <= eff[7:0];
      nptr_q <= nptr;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && rgn == bsf_pkg::RG_MEM) begin
      mem_q[apb.paddr[9:2]] <= apb.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        io_q[i] <= bsf_pkg::RF_RST;
      end
    end else begin
      if (wr && rgn == bsf_pkg::RG_IO) begin
        io_q[apb.paddr[6:2]] <= apb.pwdata[7:0];
      end
      if (st_q == bsf_pkg::ST_FIN && op == bsf_pkg::OP_IOSET) begin
        io_q[cmd_q.rd][cmd_q.bsel] <= 1'b1;
      end
      if (st_q == bsf_pkg::ST_FIN && op == bsf_pkg::OP_IOCLR) begin
        io_q[cmd_q.rd][cmd_q.bsel] <= 1'b0;
      end
    end
  end

  // a post-increment or pre-decrement load whose target is its own pointer ends with the new pointer value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= bsf_pkg::RF_RST;
      end
    end else begin
      if (wr && rgn == bsf_pkg::RG_RF) begin
        rf_q[apb.paddr[6:2]] <= apb.pwdata[7:0];
      end
      if (st_q == bsf_pkg::ST_EXEC) begin
        if (is_shift(op)) begin
          rf_q[cmd_q.rd] <= sres;
        end else if (op == bsf_pkg::OP_SWAP) begin
          rf_q[cmd_q.rd] <= {rdv[3:0], rdv[7:4]};
        end else if (op == bsf_pkg::OP_T2B) begin
          rf_q[cmd_q.rd][cmd_q.bsel] <= flags_q[bsf_pkg::F_T];
        end else if (op == bsf_pkg::OP_MOV) begin
          rf_q[cmd_q.rd] <= rrv;
        end else if (op == bsf_pkg::OP_PCPY) begin
          rf_q[{cmd_q.rd[4:1], 1'b0}] <= rf_q[{cmd_q.rr[4:1], 1'b0}];
          rf_q[{cmd_q.rd[4:1], 1'b1}] <= rf_q[{cmd_q.rr[4:1], 1'b1}];
        end else if (op == bsf_pkg::OP_IMM) begin
          rf_q[cmd_q.rd] <= cmd_q.imm;
        end
      end
      if (st_q == bsf_pkg::ST_FIN && is_mrd(op)) begin
        rf_q[cmd_q.rd] <= mem_q[addr_q];
        if (ptr_upd(op)) begin
          rf_q[pb]         <= nptr_q[7:0];
          rf_q[pb | 5'h01] <= nptr_q[15:8];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= bsf_pkg::FLG_RST;
    end else if (wr && rgn == bsf_pkg::RG_FLG) begin
      flags_q <= apb.pwdata[7:0];
    end else if (st_q == bsf_pkg::ST_EXEC) begin
      if (is_shift(op)) begin
        flags_q[bsf_pkg::F_C] <= sc;
        flags_q[bsf_pkg::F_Z] <= sres == 8'h00;
        flags_q[bsf_pkg::F_N] <= sres[7];
        flags_q[bsf_pkg::F_V] <= sres[7] ^ sc;
      end else if (op == bsf_pkg::OP_FSET) begin
        flags_q[cmd_q.bsel] <= 1'b1;
      end else if (op == bsf_pkg::OP_FCLR) begin
        flags_q[cmd_q.bsel] <= 1'b0;
      end else if (op == bsf_pkg::OP_B2T) begin
        flags_q[bsf_pkg::F_T] <= rrv[cmd_q.bsel];
      end
    end
  end

  // checks
  logic [7:0]  chk_v_q;
  logic [7:0]  chk_w_q;
  logic [7:0]  chk_f_q;
  logic [15:0] chk_p_q;
  logic        ex;
  assign ex = st_q == bsf_pkg::ST_EXEC;
  always_ff @(posedge pclk) begin
    chk_v_q <= rdv;
    chk_w_q <= rrv;
    chk_f_q <= flags_q;
    chk_p_q <= ptr;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_IOSET: assert property (ex && op == bsf_pkg::OP_IOSET |=>
    st_q == bsf_pkg::ST_FIN ##1 io_q[cmd_q.rd][cmd_q.bsel] && !busy_q && flags_q == chk_f_q)
    else $error("io bit set wrong");
  AST_IOCLR: assert property (ex && op == bsf_pkg::OP_IOCLR |=>
    ##1 !io_q[cmd_q.rd][cmd_q.bsel] && st_q == bsf_pkg::ST_IDLE)
    else $error("io bit clear wrong");
  AST_SHL: assert property (ex && op == bsf_pkg::OP_SHL |=>
    rf_q[cmd_q.rd] == {chk_v_q[6:0], 1'b0} && flags_q[bsf_pkg::F_C] == chk_v_q[7] && !busy_q)
    else $error("shift left wrong");
  AST_SHR: assert property (ex && op == bsf_pkg::OP_SHR |=>
    rf_q[cmd_q.rd] == {1'b0, chk_v_q[7:1]} && !flags_q[bsf_pkg::F_N])
    else $error("shift right wrong");
  AST_RLC: assert property (ex && op == bsf_pkg::OP_RLC |=>
    rf_q[cmd_q.rd] == {chk_v_q[6:0], chk_f_q[bsf_pkg::F_C]} &&
    flags_q[bsf_pkg::F_C] == chk_v_q[7])
    else $error("rotate left wrong");
  AST_RRC: assert property (ex && op == bsf_pkg::OP_RRC |=>
    rf_q[cmd_q.rd] == {chk_f_q[bsf_pkg::F_C], chk_v_q[7:1]} &&
    flags_q[bsf_pkg::F_C] == chk_v_q[0])
    else $error("rotate right wrong");
  AST_SWAP: assert property (ex && op == bsf_pkg::OP_SWAP |=>
    rf_q[cmd_q.rd] == {chk_v_q[3:0], chk_v_q[7:4]} && flags_q == chk_f_q)
    else $error("swap wrong");
  AST_FLAG: assert property (ex && op == bsf_pkg::OP_FSET |=>
    flags_q == (chk_f_q | (8'h01 << cmd_q.bsel)))
    else $error("flag set wrong");
  AST_MRDXI: assert property (ex && op == bsf_pkg::OP_MRD_XI && cmd_q.rd < bsf_pkg::R_X
    |=> ##1 {rf_q[bsf_pkg::R_X | 5'h01], rf_q[bsf_pkg::R_X]} == chk_p_q + 16'h0001)
    else $error("post increment wrong");
  AST_MRDXD: assert property (ex && op == bsf_pkg::OP_MRD_XD && cmd_q.rd < bsf_pkg::R_X
    |=> ##1 rf_q[cmd_q.rd] == mem_q[8'(chk_p_q - 16'h0001)])
    else $error("pre decrement wrong");
  AST_MRDYQ: assert property (ex && op == bsf_pkg::OP_MRD_YQ && cmd_q.rd < bsf_pkg::R_Y
    |=> ##1 {rf_q[bsf_pkg::R_Y | 5'h01], rf_q[bsf_pkg::R_Y]} == chk_p_q && flags_q == chk_f_q)
    else $error("displaced read wrong");
  AST_MOV: assert property (ex && op == bsf_pkg::OP_MOV |=>
    rf_q[cmd_q.rd] == chk_w_q && flags_q == chk_f_q && st_q == bsf_pkg::ST_IDLE)
    else $error("move wrong");

  COV_SHIFT: cover property (ex && is_shift(op));
  COV_LOAD: cover property (ex && op == bsf_pkg::OP_MRD_ZI ##2 launch);
  COV_WAIT: cover property (acc && busy_q && apb.pwrite);

endmodule // bsf_exec

// *** logic/bsf_pkg.sv ***
package bsf_pkg;
  // apb map
  localparam logic [11:0] A_CMD   = 12'h000;
  localparam logic [11:0] A_FLG   = 12'h004;
  localparam logic [11:0] A_RF    = 12'h100;
  localparam logic [11:0] A_IO    = 12'h200;
  localparam logic [11:0] A_MEM   = 12'h400;
  localparam logic [11:0] M_RF    = 12'h07c;
  localparam logic [11:0] M_IO    = 12'h07c;
  localparam logic [11:0] M_MEM   = 12'h3fc;
  localparam logic [7:0]  FLG_RST = 8'h00;
  localparam logic [7:0]  RF_RST  = 8'h00;
  // status flag positions
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_T = 6;
  // pointer pairs, low byte index
  localparam logic [4:0] R_X = 5'h1a;
  localparam logic [4:0] R_Y = 5'h1c;
  localparam logic [4:0] R_Z = 5'h1e;
  // execution lengths in cycles
  localparam int EX_SHORT = 1;
  localparam int EX_LONG  = 2;
  // commands
  localparam logic [4:0] OP_NOP    = 5'h00;
  localparam logic [4:0] OP_IOSET  = 5'h01;
  localparam logic [4:0] OP_IOCLR  = 5'h02;
  localparam logic [4:0] OP_SHL    = 5'h03;
  localparam logic [4:0] OP_SHR    = 5'h04;
  localparam logic [4:0] OP_RLC    = 5'h05;
  localparam logic [4:0] OP_RRC    = 5'h06;
  localparam logic [4:0] OP_SAR    = 5'h07;
  localparam logic [4:0] OP_SWAP   = 5'h08;
  localparam logic [4:0] OP_FSET   = 5'h09;
  localparam logic [4:0] OP_FCLR   = 5'h0a;
  localparam logic [4:0] OP_B2T    = 5'h0b;
  localparam logic [4:0] OP_T2B    = 5'h0c;
  localparam logic [4:0] OP_MOV    = 5'h0d;
  localparam logic [4:0] OP_PCPY   = 5'h0e;
  localparam logic [4:0] OP_IMM    = 5'h0f;
  localparam logic [4:0] OP_MRD_X  = 5'h10;
  localparam logic [4:0] OP_MRD_XI = 5'h11;
  localparam logic [4:0] OP_MRD_XD = 5'h12;
  localparam logic [4:0] OP_MRD_Y  = 5'h13;
  localparam logic [4:0] OP_MRD_YI = 5'h14;
  localparam logic [4:0] OP_MRD_YD = 5'h15;
  localparam logic [4:0] OP_MRD_YQ = 5'h16;
  localparam logic [4:0] OP_MRD_Z  = 5'h17;
  localparam logic [4:0] OP_MRD_ZI = 5'h18;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [7:0] imm;
    logic [2:0] bsel;
    logic [4:0] rr;
    logic [4:0] rd;
    logic [4:0] op;
  } bsf_cmd_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } bsf_apb_t;

  typedef enum logic [2:0] {RG_CMD, RG_FLG, RG_RF, RG_IO, RG_MEM, RG_NONE} bsf_rgn_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_FIN} bsf_st_t;
endpackage

// *** tb/bsf_host.sv ***
`timescale 1ns/1ps
module bsf_host (
  // clock
  input  wire logic         pclk,
  // apb master side
  output bsf_pkg::bsf_apb_t apb,
  input  wire logic [31:0]  prdata,
  input  wire logic         pready,
  input  wire logic         pslverr
);
  initial apb = '0;

  // request held until pready is seen high at a rising edge, released right after it
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    q = 'x;
    e = 1'bx;
    @(posedge pclk);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= wr;
    apb.paddr   <= a;
    apb.pwdata  <= d;
    @(posedge pclk);
    apb.penable <= 1'b1;
    // no assumed latency: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
    // released lines show no stale value
    apb.paddr   <= ~a;
    apb.pwdata  <= ~d;
  endtask
endmodule // bsf_host

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin miscompares++; \
  $display("[ERR] t=%0t mismatch got %h exp %h", $time, (g), (x)); end end
module testbench;
  logic              pclk;
  logic              presetn;
  bsf_pkg::bsf_apb_t apb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [7:0]        flags;
  logic              busy;
  int                miscompares;
  int                cmp_count;
  int                cycles;
  logic [7:0]        rf [32];
  logic [7:0]        io [32];
  logic [7:0]        mem [256];
  logic [7:0]        fl;
  logic [31:0]       q;
  logic              e;
  bsf_pkg::bsf_cmd_t c;

  bsf_exec i_bsf_exec (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
                       .pready(pready), .pslverr(pslverr), .flags(flags), .busy(busy));
  bsf_host i_bsf_host (.pclk(pclk), .apb(apb), .prdata(prdata), .pready(pready),
                       .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [11:0] ra(input logic [11:0] b, input int i);
    return b + 12'(i * 4);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] qq;
    logic        ee;
    i_bsf_host.xfer(1'b1, a, d, qq, ee);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] qq;
    logic        ee;
    i_bsf_host.xfer(1'b0, a, 32'h0, qq, ee);
    `CHK(qq, x)
    `CHK(ee, 1'b0)
  endtask

  task automatic run(input bsf_pkg::bsf_cmd_t k);
    int          lat;
    int          i;
    logic        lng;
    logic [7:0]  r;
    logic [7:0]  res;
    logic [4:0]  pb;
    logic [15:0] p;
    r = rf[k.rd];
    res = r;
    lng = (k.op inside {bsf_pkg::OP_IOSET, bsf_pkg::OP_IOCLR}) || (k.op inside {[5'h10:5'h18]});
    case (k.op)
      bsf_pkg::OP_IOSET: io[k.rd][k.bsel] = 1'b1;
      bsf_pkg::OP_IOCLR: io[k.rd][k.bsel] = 1'b0;
      bsf_pkg::OP_SHL:   {fl[bsf_pkg::F_C], res} = {r, 1'b0};
      bsf_pkg::OP_SHR:   {res, fl[bsf_pkg::F_C]} = {1'b0, r};
      bsf_pkg::OP_RLC:   {fl[bsf_pkg::F_C], res} = {r, fl[bsf_pkg::F_C]};
      bsf_pkg::OP_RRC:   {res, fl[bsf_pkg::F_C]} = {fl[bsf_pkg::F_C], r};
      bsf_pkg::OP_SAR:   {res, fl[bsf_pkg::F_C]} = {r[7], r};
      bsf_pkg::OP_SWAP:  res = {r[3:0], r[7:4]};
      bsf_pkg::OP_FSET:  fl[k.bsel] = 1'b1;
      bsf_pkg::OP_FCLR:  fl[k.bsel] = 1'b0;
      bsf_pkg::OP_B2T:   fl[bsf_pkg::F_T] = rf[k.rr][k.bsel];
      bsf_pkg::OP_T2B:   res[k.bsel] = fl[bsf_pkg::F_T];
      bsf_pkg::OP_MOV:   res = rf[k.rr];
      bsf_pkg::OP_IMM:   res = k.imm;
      default:           res = r;
    endcase
    if (k.op inside {[bsf_pkg::OP_SHL:bsf_pkg::OP_SAR]}) begin
      fl[bsf_pkg::F_Z] = (res == 8'h00);
      fl[bsf_pkg::F_N] = res[7];
      fl[bsf_pkg::F_V] = res[7] ^ fl[bsf_pkg::F_C];
    end
    rf[k.rd] = res;
    if (k.op == bsf_pkg::OP_PCPY) begin
      rf[k.rd & 5'h1e] = rf[k.rr & 5'h1e];
      rf[k.rd | 5'h01] = rf[k.rr | 5'h01];
    end
    pb = (k.op < bsf_pkg::OP_MRD_Y) ? bsf_pkg::R_X :
         (k.op < bsf_pkg::OP_MRD_Z) ? bsf_pkg::R_Y : bsf_pkg::R_Z;
    p = {rf[5'(pb + 1)], rf[pb]};
    if (k.op inside {bsf_pkg::OP_MRD_XD, bsf_pkg::OP_MRD_YD}) p = p - 16'h1;
    if (k.op inside {[bsf_pkg::OP_MRD_X:bsf_pkg::OP_MRD_ZI]}) begin
      // only the low pointer byte reaches the data memory
      rf[k.rd] = mem[8'(p + ((k.op == bsf_pkg::OP_MRD_YQ) ? 16'(k.imm[5:0]) : 16'h0))];
      if (k.op inside {bsf_pkg::OP_MRD_XI, bsf_pkg::OP_MRD_YI, bsf_pkg::OP_MRD_ZI}) p = p + 16'h1;
      if (k.op inside {bsf_pkg::OP_MRD_XI, bsf_pkg::OP_MRD_XD, bsf_pkg::OP_MRD_YI,
                       bsf_pkg::OP_MRD_YD, bsf_pkg::OP_MRD_ZI}) begin
        {rf[5'(pb + 1)], rf[pb]} = p;
      end
    end
    wr(bsf_pkg::A_CMD, 32'(k));
    lat = 0;
    do begin
      @(negedge pclk);
      lat++;
    end while (busy === 1'b1 && lat < 10);
    `CHK(lat - 1, lng ? bsf_pkg::EX_LONG : bsf_pkg::EX_SHORT)
    repeat (3) @(posedge pclk);
    `CHK(flags, fl)
    rdchk(bsf_pkg::A_FLG, {24'h0, fl});
    rdchk(ra(bsf_pkg::A_RF, k.rd), {24'h0, rf[k.rd]});
    rdchk(ra(bsf_pkg::A_RF, k.rd ^ 5'h01), {24'h0, rf[k.rd ^ 5'h01]});
    rdchk(ra(bsf_pkg::A_IO, k.rd), {24'h0, io[k.rd]});
    for (i = 26; i < 32; i++) begin
      rdchk(ra(bsf_pkg::A_RF, i), {24'h0, rf[i]});
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // sized for roughly three and a half times the expected run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    presetn = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    void'($urandom(93));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(bsf_pkg::A_FLG, 32'h0);
    for (int i = 0; i < 32; i++) begin
      rdchk(ra(bsf_pkg::A_RF, i), 32'h0);
      rdchk(ra(bsf_pkg::A_IO, i), 32'h0);
    end
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      wr(i ? 12'h280 : 12'h008, 32'hffff_ffff);
      i_bsf_host.xfer(1'b0, i ? 12'h280 : 12'h008, 32'h0, q, e);
      `CHK(q, 32'h0)
      `CHK(e, 1'b1)
    end
    $display("test unmapped done");
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      wr(ra(bsf_pkg::A_MEM, i), {24'h0, mem[i]});
      if (i < 32) begin
        rf[i] = 8'($urandom);
        io[i] = 8'($urandom);
        wr(ra(bsf_pkg::A_RF, i), {24'h0, rf[i]});
        wr(ra(bsf_pkg::A_IO, i), {24'h0, io[i]});
      end
    end
    fl = 8'($urandom);
    wr(bsf_pkg::A_FLG, {24'h0, fl});
    $display("test preload done");
    for (int k = 0; k < 300; k++) begin
      c = {6'h00, 8'($urandom), 3'($urandom), 5'($urandom), 5'($urandom), 5'(k)};
      run(c);
    end
    rdchk(bsf_pkg::A_CMD, 32'(c));
    $display("test commands done");
    report_and_stop();
  end
endmodule // testbench
